// file: logic/dfp_supervisor.v
// drive fault protection supervisor: latches trips, blocks the power stage
// assumes comparator flags come from pins (synchronised here) and that
// the serial command word comes from logic on the same clock
`timescale 1ns/1ps
`include "dfp_consts.vh"
module dfp_supervisor #(
  parameter NUM_MF = 8,
  parameter [35:0] OL_CYCLES = `DFP_OL_CYCLES,
  parameter [31:0] KP_CYCLES = `DFP_KP_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // comparator and status pins
  input wire over_current,
  input wire arm_short,
  input wire out_short,
  input wire ground_over,
  input wire over_150pct,
  input wire heatsink_hot,
  input wire [2:0] out_phase_open,
  input wire bus_above_400v,
  input wire bus_below_180v,
  input wire motor_thermal_trip,
  input wire [2:0] in_phase_open,
  input wire cap_worn,
  input wire thermistor_open,
  input wire param_save_fail,
  input wire control_hw_fault,
  input wire fan_fault,
  input wire diag_fail,
  // keypad links
  input wire remote_keypad_ok,
  input wire keypad_fault,
  // emergency stop and run inputs
  input wire emergency_stop_input,
  input wire forward_run_input,
  input wire reverse_run_input,
  // multifunction inputs and their selectors
  input wire [NUM_MF-1:0] mf_input,
  input wire [5*NUM_MF-1:0] multifunction_input_selectors,
  // reference loss
  input wire ref_from_analog_or_serial,
  input wire ref_present,
  input wire [1:0] reference_loss_method_setting,
  // brake control
  input wire brake_active,
  input wire current_below_release,
  // serial command word, same clock domain
  input wire [15:0] command_word,
  // outputs
  output reg output_block_ff,
  output reg brake_release_ff,
  output reg decel_stop_ff,
  output reg [4:0] fault_code_ff,
  output reg fault_latched_ff,
  output reg remote_keypad_err_ff,
  output reg keypad_reset_ff,
  output reg keypad_err_ff,
  output reg estop_active_ff
);

  // =====================================================================
  // input synchronisers
  // =====================================================================
  localparam NPIN = 30 + NUM_MF;
  wire [NPIN-1:0] pin_raw;
  assign pin_raw = {mf_input, over_current, arm_short, out_short, ground_over,
    over_150pct, heatsink_hot, out_phase_open, bus_above_400v, bus_below_180v,
    motor_thermal_trip, in_phase_open, cap_worn, thermistor_open,
    param_save_fail, control_hw_fault, fan_fault, diag_fail, remote_keypad_ok,
    keypad_fault, emergency_stop_input, forward_run_input, reverse_run_input,
    ref_present, brake_active, current_below_release, 1'b0};
  reg [NPIN-1:0] s1_ff, s2_ff, s3_ff, pin_ff;
  // every stage resets low, which is not the idle level of every pin, so a
  // warm-up count hides conditions until the filtered levels are real
  reg [3:0] warm_ff;

  // a change counts only once stages two and three agree, filtering one glitch
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff <= {NPIN{1'b0}};
      s2_ff <= {NPIN{1'b0}};
      s3_ff <= {NPIN{1'b0}};
      pin_ff <= {NPIN{1'b0}};
      warm_ff <= 4'h0;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pin_ff <= (s2_ff & s3_ff) | (pin_ff & (s2_ff | s3_ff));
      warm_ff <= {warm_ff[2:0], 1'b1};
    end
  end

  wire [NUM_MF-1:0] q_mf = pin_ff[NPIN-1:30];
  wire q_oc = pin_ff[29];
  wire q_arm = pin_ff[28];
  wire q_osh = pin_ff[27];
  wire q_gnd = pin_ff[26];
  wire q_150 = pin_ff[25];
  wire q_hot = pin_ff[24];
  wire q_opl = |pin_ff[23:21];
  wire q_ov = pin_ff[20];
  wire q_uv = pin_ff[19];
  wire q_mth = pin_ff[18];
  wire q_ipl = |pin_ff[17:15] | pin_ff[14];
  wire q_ntc = pin_ff[13];
  wire q_save = pin_ff[12];
  wire q_hw = pin_ff[11];
  wire q_fan = pin_ff[10];
  wire q_diag = pin_ff[9];
  wire q_rkp = pin_ff[8];
  wire q_kpf = pin_ff[7];
  wire q_est = pin_ff[6];
  wire q_fx = pin_ff[5];
  wire q_rx = pin_ff[4];
  wire q_ref = pin_ff[3];
  wire q_brk = pin_ff[2];
  wire q_low = pin_ff[1];

  // =====================================================================
  // external fault inputs
  // =====================================================================
  // true when any input with the given selector code is in its fault level
  function ext_hit;
    input [5*NUM_MF-1:0] sel;
    input [NUM_MF-1:0] lvl;
    input [4:0] code;
    input inv;
    integer i;
    begin
      ext_hit = 1'b0;
      for (i = 0; i < NUM_MF; i = i + 1) begin
        if (sel[5*i +: 5] == code && (lvl[i] ^ inv))
          ext_hit = 1'b1;
      end
    end
  endfunction

  wire ext_a = ext_hit(multifunction_input_selectors, q_mf, `DFP_SEL_EXT_NO, 1'b0);
  wire ext_b = ext_hit(multifunction_input_selectors, q_mf, `DFP_SEL_EXT_NC, 1'b1);
  wire ref_lost = warm_ff[3] & ref_from_analog_or_serial & ~q_ref;

  // =====================================================================
  // overload timer
  // =====================================================================
  reg [35:0] ol_cnt_ff;
  wire ol_done = (ol_cnt_ff >= OL_CYCLES - 36'h1);

  // counts only while current stays above 150 percent without a break
  always @(posedge clk or posedge reset) begin
    if (reset)
      ol_cnt_ff <= 36'h0;
    else if (!q_150)
      ol_cnt_ff <= 36'h0;
    else if (!ol_done)
      ol_cnt_ff <= ol_cnt_ff + 36'h1;
  end

  // overload and overload trip share one timer; drive overload is reported
  wire trip_iol = q_150 & ol_done;

  // =====================================================================
  // present conditions in priority order
  // =====================================================================
  wire brake_fault = q_brk & q_low;
  reg [4:0] cond_code;
  // nothing is judged before warm-up ends
  always @* begin
    cond_code = `DFP_FC_NONE;
    if (!warm_ff[3]) cond_code = `DFP_FC_NONE;
    else if (q_oc) cond_code = `DFP_FC_OC1;
    else if (q_arm & q_osh) cond_code = `DFP_FC_OC2;
    else if (q_gnd) cond_code = `DFP_FC_GND;
    else if (trip_iol) cond_code = `DFP_FC_IOL;
    else if (q_hot) cond_code = `DFP_FC_OHT;
    else if (q_opl) cond_code = `DFP_FC_OPL;
    else if (q_ov) cond_code = `DFP_FC_OV;
    else if (q_uv) cond_code = `DFP_FC_UV;
    else if (q_mth) cond_code = `DFP_FC_MTH;
    else if (q_ipl) cond_code = `DFP_FC_IPL;
    else if (ext_a) cond_code = `DFP_FC_EXTA;
    else if (ext_b) cond_code = `DFP_FC_EXTB;
    else if (q_ntc) cond_code = `DFP_FC_NTC;
    else if (brake_fault) cond_code = `DFP_FC_BRK;
    else if (q_save) cond_code = `DFP_FC_SAVE;
    else if (q_hw) cond_code = `DFP_FC_HW;
    else if (q_fan) cond_code = `DFP_FC_FAN;
    else if (q_diag) cond_code = `DFP_FC_DIAG;
    else if (ref_lost && reference_loss_method_setting == `DFP_REFL_TRIP)
      cond_code = `DFP_FC_REFL;
  end

  // =====================================================================
  // fault latch and clear
  // =====================================================================
  reg cmd_bit_ff;
  wire clr_req = command_word[`DFP_CMD_RESET_BIT] & ~cmd_bit_ff;
  wire cond_any = (cond_code != `DFP_FC_NONE);
  reg [4:0] nxt_code;

  // a new condition wins over a clear in the same cycle
  always @* begin
    nxt_code = fault_code_ff;
    if (fault_code_ff == `DFP_FC_NONE)
      nxt_code = cond_code;
    else if (clr_req && !cond_any)
      nxt_code = `DFP_FC_NONE;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_bit_ff <= 1'b0;
      fault_code_ff <= `DFP_FC_NONE;
      fault_latched_ff <= 1'b0;
    end else begin
      cmd_bit_ff <= command_word[`DFP_CMD_RESET_BIT];
      fault_code_ff <= nxt_code;
      fault_latched_ff <= (nxt_code != `DFP_FC_NONE);
    end
  end

  // =====================================================================
  // emergency stop
  // =====================================================================
  reg nxt_est;
  // stays stopped after release until a run input is on
  always @* begin
    nxt_est = estop_active_ff;
    if (q_est)
      nxt_est = 1'b1;
    else if (q_fx | q_rx)
      nxt_est = 1'b0;
  end

  always @(posedge clk or posedge reset) begin
    if (reset)
      estop_active_ff <= 1'b0;
    else
      estop_active_ff <= nxt_est;
  end

  // =====================================================================
  // keypad supervision
  // =====================================================================
  reg [31:0] kp_cnt_ff;

  // pulse a keypad reset on entry, then count how long the fault persists
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      kp_cnt_ff <= 32'h0;
      keypad_reset_ff <= 1'b0;
      keypad_err_ff <= 1'b0;
      remote_keypad_err_ff <= 1'b0;
    end else begin
      remote_keypad_err_ff <= ~q_rkp & warm_ff[3];
      keypad_reset_ff <= q_kpf & (kp_cnt_ff == 32'h0);
      if (!q_kpf) begin
        kp_cnt_ff <= 32'h0;
        keypad_err_ff <= 1'b0;
      end else if (kp_cnt_ff < KP_CYCLES[31:0]) begin
        kp_cnt_ff <= kp_cnt_ff + 32'h1;
      end else begin
        keypad_err_ff <= 1'b1;
      end
    end
  end

  // =====================================================================
  // output block, brake and reference loss action
  // =====================================================================
  // keypad errors deliberately do not enter the block term; the bridge stays
  // off through warm-up so no trip can slip past before the pins are seen
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      output_block_ff <= 1'b1;
      brake_release_ff <= 1'b0;
      decel_stop_ff <= 1'b0;
    end else begin
      output_block_ff <= (nxt_code != `DFP_FC_NONE) | nxt_est | ~warm_ff[3];
      brake_release_ff <= q_brk & ~brake_fault & (nxt_code == `DFP_FC_NONE);
      decel_stop_ff <= ref_lost &
        (reference_loss_method_setting == `DFP_REFL_DECEL);
    end
  end

endmodule

// file: logic/dfp_consts.vh
// constants for the drive fault protection supervisor
// assumes a 200 MHz clock; included by the supervisor module
`ifndef DFP_CONSTS_VH
`define DFP_CONSTS_VH
// fault codes, first latched condition wins
`define DFP_FC_NONE 5'h00
`define DFP_FC_OC1 5'h01
`define DFP_FC_OC2 5'h02
`define DFP_FC_GND 5'h03
`define DFP_FC_IOL 5'h04
`define DFP_FC_OLT 5'h05
`define DFP_FC_OHT 5'h06
`define DFP_FC_OPL 5'h07
`define DFP_FC_OV 5'h08
`define DFP_FC_UV 5'h09
`define DFP_FC_MTH 5'h0a
`define DFP_FC_IPL 5'h0b
`define DFP_FC_ESTOP 5'h0c
`define DFP_FC_EXTA 5'h0d
`define DFP_FC_EXTB 5'h0e
`define DFP_FC_NTC 5'h0f
`define DFP_FC_BRK 5'h10
`define DFP_FC_SAVE 5'h11
`define DFP_FC_HW 5'h12
`define DFP_FC_FAN 5'h13
`define DFP_FC_DIAG 5'h14
`define DFP_FC_REFL 5'h15
// selector codes for the multifunction inputs
`define DFP_SEL_EXT_NO 5'h12
`define DFP_SEL_EXT_NC 5'h13
// reference loss methods: keep running, coast stop (trip), decel stop
`define DFP_REFL_RUN 2'h0
`define DFP_REFL_TRIP 2'h1
`define DFP_REFL_DECEL 2'h2
// command word bit that requests a fault reset
`define DFP_CMD_RESET_BIT 2
// overload time 1 min = 60 s at 200 MHz; the clock rate is sized so the
// product is formed in 36 bits instead of wrapping at 32
`define DFP_OL_TIME_S 60
`define DFP_CLK_HZ 36'h00bebc200
`define DFP_OL_CYCLES (`DFP_OL_TIME_S * `DFP_CLK_HZ)
// keypad persistence time in us
`define DFP_KP_TIME_US 100000
`define DFP_KP_CYCLES (`DFP_KP_TIME_US * 200)
`endif

// file: test/dfp_sup_props.sv
// checker for the fault supervisor, bound to its top-level ports
// assumes pins are held for at least three clock cycles at a time
`timescale 1ns/1ps
// ====================
// protection checks
module dfp_sup_props (
  // clock and reset
  input wire clk,
  input wire reset,
  // pins and command word
  input wire over_current,
  input wire emergency_stop_input,
  input wire brake_active,
  input wire current_below_release,
  input wire [15:0] command_word,
  // outputs
  input wire output_block_ff,
  input wire brake_release_ff,
  input wire [4:0] fault_code_ff,
  input wire fault_latched_ff,
  input wire keypad_reset_ff,
  input wire estop_active_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // sync stages, filter and output flop bound every pin-to-block delay
  a_oc_block: assert property (over_current [*3] |-> ##[1:4] output_block_ff)
    else $error("no block on overcurrent");
  a_estop_cut: assert property (
    emergency_stop_input [*3] |-> ##[1:4] (estop_active_ff && output_block_ff))
    else $error("no cut on emergency stop");
  a_brake_kept: assert property (
    (brake_active && current_below_release) [*3] |-> ##[1:4]
    (output_block_ff && !brake_release_ff))
    else $error("brake fault handled wrongly");
  a_clear_refused: assert property (
    (over_current [*6] ##0 fault_latched_ff) |=> fault_latched_ff)
    else $error("clear taken with cause present");
  // no rise of the reset bit means the first code must not move
  a_code_held: assert property (
    (fault_latched_ff && !command_word[2] ##1 !command_word[2])
    |-> fault_code_ff == $past(fault_code_ff))
    else $error("fault code changed while latched");
  a_latch_block: assert property (fault_latched_ff |-> output_block_ff)
    else $error("latched fault without block");
  a_first_code: assert property ($rose(fault_latched_ff) |-> fault_code_ff != 5'h00)
    else $error("latched fault without code");
  a_kp_pulse: assert property (keypad_reset_ff |=> !keypad_reset_ff)
    else $error("keypad reset longer than one cycle");
endmodule

bind dfp_supervisor dfp_sup_props dfp_sup_props_u (.clk, .reset, .over_current,
  .emergency_stop_input, .brake_active, .current_below_release, .command_word,
  .output_block_ff, .brake_release_ff, .fault_code_ff, .fault_latched_ff, .keypad_reset_ff,
  .estop_active_ff);

// file: test/dfp_load_model.sv
// power stage and load: a heavy load shows 150 percent current
// assumes the bench sets heavy_load away from the rising clock edge
`timescale 1ns/1ps
// ====================
// load model
module dfp_load_model (
  // controls
  input wire heavy_load,
  input wire output_block_ff,
  // sensed current flag
  output wire over_150pct
);
  // a blocked bridge carries no current, so the flag drops at a trip
  assign over_150pct = heavy_load & ~output_block_ff;
endmodule

// file: test/dfp_supervisor_tb_top.sv
// bench for the fault supervisor: trips, clears, stop, reference and keypad
// assumes the checker is bound and the long counts are shortened
`timescale 1ns/1ps
// ====================
// bench top
module dfp_supervisor_tb_top;
  localparam [35:0] OLC = 36'h64;
  localparam [31:0] KPC = 32'h14;
  // each entry: fault code byte, then the pins that raise it
  localparam [755:0] TE = {36'h151000000, 36'h0e0800000, 36'h0d0400000, 36'h100300000,
    36'h140002000, 36'h130001000, 36'h120000800, 36'h110000400, 36'h0f0000200, 36'h0b0000100,
    36'h0b0080000, 36'h0b0020000, 36'h0a0000080, 36'h090000040, 36'h080000020, 36'h070010000,
    36'h070004000, 36'h060000010, 36'h030000008, 36'h020000006, 36'h010000001};
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [24:0] f = 25'h0;
  reg heavy_load = 1'b0, keypad_fault = 1'b0, emergency_stop_input = 1'b0;
  reg forward_run_input = 1'b0, reverse_run_input = 1'b0, kp_seen = 1'b0;
  reg remote_keypad_ok = 1'b1;
  reg [1:0] reference_loss_method_setting = 2'h1;
  reg [15:0] command_word = 16'h0000;
  wire over_150pct, output_block_ff, brake_release_ff, decel_stop_ff, fault_latched_ff;
  wire remote_keypad_err_ff, keypad_reset_ff, keypad_err_ff, estop_active_ff;
  wire [4:0] fault_code_ff;
  integer mismatches = 0, n_tests = 0, i;
  dfp_supervisor #(.NUM_MF(8), .OL_CYCLES(OLC), .KP_CYCLES(KPC)) dut_u (.clk, .reset,
    .over_current(f[0]), .arm_short(f[1]), .out_short(f[2]), .ground_over(f[3]),
    .over_150pct, .heatsink_hot(f[4]), .out_phase_open(f[16:14]), .bus_above_400v(f[5]),
    .bus_below_180v(f[6]), .motor_thermal_trip(f[7]), .in_phase_open(f[19:17]),
    .cap_worn(f[8]), .thermistor_open(f[9]), .param_save_fail(f[10]),
    .control_hw_fault(f[11]), .fan_fault(f[12]), .diag_fail(f[13]), .remote_keypad_ok,
    .keypad_fault, .emergency_stop_input, .forward_run_input, .reverse_run_input,
    .mf_input({6'h00, ~f[23], f[22]}), .multifunction_input_selectors({30'h0, 5'h13, 5'h12}),
    .ref_from_analog_or_serial(1'b1), .ref_present(~f[24]), .reference_loss_method_setting,
    .brake_active(f[20]), .current_below_release(f[21]), .command_word, .output_block_ff,
    .brake_release_ff, .decel_stop_ff, .fault_code_ff, .fault_latched_ff,
    .remote_keypad_err_ff, .keypad_reset_ff, .keypad_err_ff, .estop_active_ff);
  dfp_load_model load_u (.heavy_load, .output_block_ff, .over_150pct);
  initial forever #2.5 clk = ~clk;
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input [4:0] got, input [4:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // flags get a compare of their own so nothing is padded
  task chk_bit(input got, input exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // the clear needs a low cycle first, so the bit rests low between calls
  task clr;
    command_word[2] = 1'b1;
    cyc(2);
    command_word[2] = 1'b0;
    cyc(2);
  endtask
  // every cause but overload trips alone; a clear is refused until the cause is gone
  task t_trips;
    for (i = 0; i < 21; i = i + 1) begin
      f = TE[36*i +: 25];
      cyc(8);
      chk(fault_code_ff, TE[36*i+28 +: 5]);
      chk_bit(output_block_ff, 1'b1);
      clr;
      chk_bit(fault_latched_ff, 1'b1);
      chk(fault_code_ff, TE[36*i+28 +: 5]);
      f = 25'h0;
      cyc(8);
      clr;
      chk(fault_code_ff, 5'h00);
      chk_bit(output_block_ff, 1'b0);
    end
  endtask
  // sustained heavy load trips only once the overload count runs out
  task t_overload;
    heavy_load = 1'b1;
    cyc(OLC[31:0] - 32'h14);
    chk_bit(fault_latched_ff, 1'b0);
    cyc(40);
    chk(fault_code_ff, 5'h04);
    heavy_load = 1'b0;
    clr;
    chk_bit(output_block_ff, 1'b0);
  endtask
  // stop released, then forward run switched on; then released with reverse run already on
  task t_estop;
    emergency_stop_input = 1'b1;
    cyc(8);
    chk_bit(output_block_ff, 1'b1);
    chk_bit(estop_active_ff, 1'b1);
    emergency_stop_input = 1'b0;
    cyc(8);
    chk_bit(output_block_ff, 1'b1);
    forward_run_input = 1'b1;
    cyc(8);
    chk_bit(output_block_ff, 1'b0);
    chk_bit(estop_active_ff, 1'b0);
    forward_run_input = 1'b0;
    emergency_stop_input = 1'b1;
    reverse_run_input = 1'b1;
    cyc(8);
    chk_bit(output_block_ff, 1'b1);
    emergency_stop_input = 1'b0;
    cyc(8);
    chk_bit(output_block_ff, 1'b0);
    reverse_run_input = 1'b0;
  endtask
  // the method is unsynchronised, so it returns to trip only after the
  // synchronised reference has come back
  task t_decel;
    reference_loss_method_setting = 2'h2;
    f[24] = 1'b1;
    cyc(8);
    chk_bit(decel_stop_ff, 1'b1);
    chk_bit(fault_latched_ff, 1'b0);
    reference_loss_method_setting = 2'h0;
    cyc(2);
    chk_bit(decel_stop_ff, 1'b0);
    chk_bit(output_block_ff, 1'b0);
    f[24] = 1'b0;
    cyc(8);
    reference_loss_method_setting = 2'h1;
  endtask
  task t_keypad;
    remote_keypad_ok = 1'b0;
    keypad_fault = 1'b1;
    kp_seen = 1'b0;
    repeat (KPC / 2) begin
      cyc(1);
      if (keypad_reset_ff === 1'b1)
        kp_seen = 1'b1;
    end
    chk_bit(kp_seen, 1'b1);
    chk_bit(keypad_err_ff, 1'b0);
    cyc(KPC + 32'h5);
    chk_bit(keypad_err_ff, 1'b1);
    chk_bit(remote_keypad_err_ff, 1'b1);
    chk_bit(output_block_ff, 1'b0);
    remote_keypad_ok = 1'b1;
    keypad_fault = 1'b0;
    cyc(8);
    chk_bit(keypad_err_ff, 1'b0);
    chk_bit(remote_keypad_err_ff, 1'b0);
  endtask
  // brake released while current is fine, held and tripped when it is low
  task t_brake;
    f[20] = 1'b1;
    cyc(8);
    chk_bit(brake_release_ff, 1'b1);
    f[21] = 1'b1;
    cyc(8);
    chk_bit(brake_release_ff, 1'b0);
    chk(fault_code_ff, 5'h10);
    f = 25'h0;
    cyc(8);
    clr;
    chk_bit(output_block_ff, 1'b0);
  endtask
  // a reset in mid-run drops a latched fault and warms up again
  task t_reset;
    f[0] = 1'b1;
    cyc(8);
    chk(fault_code_ff, 5'h01);
    reset = 1'b1;
    f = 25'h0;
    cyc(2);
    chk(fault_code_ff, 5'h00);
    chk_bit(output_block_ff, 1'b1);
    cyc(2);
    reset = 1'b0;
    cyc(6);
    chk_bit(output_block_ff, 1'b0);
    chk_bit(fault_latched_ff, 1'b0);
  endtask
  task print_verdict;
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence: block shown during reset, clear after release
  initial begin
    cyc(2);
    chk_bit(output_block_ff, 1'b1);
    cyc(2);
    reset = 1'b0;
    // the block holds through the four edges of warm-up
    cyc(6);
    chk_bit(output_block_ff, 1'b0);
    t_trips;
    t_overload;
    t_estop;
    t_decel;
    t_keypad;
    t_brake;
    t_reset;
    print_verdict;
  end
  // watchdog well beyond the roughly eight hundred cycles of the run
  initial begin
    #100000;
    mismatches = mismatches + 1;
    print_verdict;
  end
endmodule
